// [bp_ctl.sv]
// Behavioural backplane test controller.
// Assumes the caller sequences the TAP; the clock stands still between steps.
`timescale 1ns/1ps
module bp_ctl (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One 125 ns period; data-out is taken just before the rise.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #62.5 tdo = i_tdo;
    o_tck = 1'b1;
    #62.5 o_tck = 1'b0;
    o_tdi = ~tdi; // Released data-in is not left at its last value.
  endtask : step
endmodule : bp_ctl

// [bridge_pkg.sv]
// Shared types and constants for the multidrop test-access bridge.
// Assumes one core clock; the backplane test clock arrives as a sampled pin.
package bridge_pkg;

  // ==========================================================================
  // Backplane TAP controller states, one-hot.
  typedef enum logic [15:0] {
    TAP_RESET    = 16'h0001,
    TAP_IDLE     = 16'h0002,
    TAP_SEL_DR   = 16'h0004,
    TAP_CAP_DR   = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR   = 16'h0100,
    TAP_SEL_IR   = 16'h0200,
    TAP_CAP_IR   = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR   = 16'h8000
  } tap_state_t;

  // Bridge selection states.
  typedef enum logic [3:0] {
    SEL_WAIT   = 4'h1,
    SEL_SINGLE = 4'h2,
    SEL_GROUP  = 4'h4,
    SEL_NONE   = 4'h8
  } sel_state_t;

  // Local scan port states: four parked states and the following state.
  typedef enum logic [4:0] {
    PORT_PARK_TLR = 5'h01,
    PORT_PARK_RTI = 5'h02,
    PORT_PARK_PDR = 5'h04,
    PORT_PARK_PIR = 5'h08,
    PORT_ACTIVE   = 5'h10
  } port_state_t;

  // Commands from the decoder to each local port controller.
  typedef struct packed {
    logic force_tlr;  // Level: park in reset regardless of state.
    logic park_tlr;   // One cycle: park active ports in reset.
    logic park_rti;   // One cycle: park active ports in idle.
    logic pause_arm;  // Level: park-pause instruction is current.
    logic unpark_arm; // Level: unpark instruction is current.
  } port_ctl_t;

  // Synchronised backplane and strap pins.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic oe_n;
    logic local_port_network_tdo;
    logic [5:0] slot;
  } pin_sample_t;

  // ==========================================================================
  // Opcodes.
  localparam logic [7:0] bypass_cmd = 8'hFF;
  localparam logic [7:0] extest_cmd = 8'h00;
  localparam logic [7:0] sample_cmd = 8'h81;
  localparam logic [7:0] idcode_cmd = 8'hAA;
  localparam logic [7:0] unpark_cmd = 8'hE7;
  localparam logic [7:0] hold_ports_in_reset_cmd = 8'hC5;
  localparam logic [7:0] hold_ports_in_idle_cmd = 8'h84;
  localparam logic [7:0] hold_ports_in_pause_cmd = 8'hC6;
  localparam logic [7:0] return_to_wait_cmd = 8'hC3;
  localparam logic [7:0] mode_register_select_cmd = 8'h8E;
  localparam logic [7:0] group_register_select_cmd = 8'h03;
  localparam logic [7:0] port_soft_reset_cmd = 8'h88;
  localparam logic [7:0] signature_register_select_cmd = 8'hC9;
  localparam logic [7:0] signature_capture_on_cmd = 8'h0C;
  localparam logic [7:0] signature_capture_off_cmd = 8'h8D;
  localparam logic [7:0] clock_counter_select_cmd = 8'hCE;
  localparam logic [7:0] clock_countdown_on_cmd = 8'h0F;
  localparam logic [7:0] clock_countdown_off_cmd = 8'h90;

  // ==========================================================================
  // Level-1 addressing.
  localparam logic [5:0] addr_direct_max = 6'h3A;
  localparam logic [5:0] addr_broadcast = 6'h3B;
  localparam logic [3:0] addr_group_prefix = 4'hF;
  localparam logic [1:0] ir_capture_low = 2'h1;

  // Data register lengths.
  localparam logic [5:0] len_bypass = 6'h01;
  localparam logic [5:0] len_boundary = 6'h07;
  localparam logic [5:0] len_ident = 6'h20;
  localparam logic [5:0] len_mode = 6'h08;
  localparam logic [5:0] len_group = 6'h02;
  localparam logic [5:0] len_signature = 6'h10;
  localparam logic [5:0] len_counter = 6'h20;

  // Reset values and mode register fields.
  localparam logic [1:0] group_reset = 2'h0;
  localparam logic [7:0] mode_reset = 8'h07;
  localparam int mode_cnt_status_bit = 7;
  localparam int port_count = 3;

  // Standard TAP transition.
  function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
    unique case (s)
      TAP_RESET:    tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:     tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR:   tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default:      tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

endpackage : bridge_pkg

// [bridge_tap_fsm.sv]
// Backplane TAP controller, stepped by a test-clock rising-edge enable.
// Assumes i_step and i_tms come from synchronised pins on the core clock.
`timescale 1ns/1ps
module bridge_tap_fsm
  import bridge_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_step,
  input wire logic i_tms,
  output tap_state_t o_state,
  output tap_state_t o_next
);

  // ==========================================================================
  // State record.
  typedef struct packed {
    tap_state_t st;
  } tap_reg_t;

  tap_reg_t q_ff; // Registered state.
  tap_reg_t nxt_q; // Next state.

  // The next state is shown so the parent can act as a state is entered.
  always_comb begin
    o_next = tap_next(q_ff.st, i_tms);
    nxt_q = q_ff;
    if (i_step) begin
      nxt_q.st = o_next;
    end
  end

  // Synchronous reset lands in Test-Logic-Reset.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q_ff.st <= TAP_RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_state = q_ff.st;

endmodule : bridge_tap_fsm

// [local_port_ctrl.sv]
// One local scan port: park and unpark sequencing and its mode-select drive.
// Assumes the parent steps it with the backplane TAP and decodes commands.
`timescale 1ns/1ps
module local_port_ctrl
  import bridge_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_step,
  input tap_state_t i_tap_state,
  input tap_state_t i_tap_next,
  input wire logic i_tms_b,
  input wire logic i_enable,
  input port_ctl_t i_ctl,
  output logic o_tms_l,
  output logic o_unparked
);

  // ==========================================================================
  // State record: port state and the registered mode-select drive.
  typedef struct packed {
    port_state_t st;
    logic tms;
  } port_reg_t;

  port_reg_t q_ff; // Registered state.
  port_reg_t nxt_q; // Next state.
  logic wake_idle; // Unpark is armed for this port.

  // Reset and idle parking act at once; pause parking and unparking wait for the matching TAP state.
  always_comb begin
    nxt_q = q_ff;
    wake_idle = i_ctl.unpark_arm && i_enable;
    if (i_ctl.force_tlr) begin
      nxt_q.st = PORT_PARK_TLR;
    end else if (i_ctl.park_tlr && q_ff.st == PORT_ACTIVE) begin
      nxt_q.st = PORT_PARK_TLR;
    end else if (i_ctl.park_rti && q_ff.st == PORT_ACTIVE) begin
      nxt_q.st = PORT_PARK_RTI;
    end else if (i_step) begin
      unique case (q_ff.st)
        PORT_ACTIVE: begin
          // Leaving Exit1 with mode-select high parks in the pause state.
          if (i_ctl.pause_arm && i_tms_b && i_tap_state == TAP_EXIT1_DR) begin
            nxt_q.st = PORT_PARK_PDR;
          end else if (i_ctl.pause_arm && i_tms_b && i_tap_state == TAP_EXIT1_IR) begin
            nxt_q.st = PORT_PARK_PIR;
          end
        end
        PORT_PARK_TLR, PORT_PARK_RTI: begin
          if (wake_idle && i_tap_next == TAP_IDLE) begin
            nxt_q.st = PORT_ACTIVE;
          end
        end
        PORT_PARK_PDR: begin
          if ((wake_idle || i_ctl.pause_arm) && i_tap_next == TAP_PAUSE_DR) begin
            nxt_q.st = PORT_ACTIVE;
          end
        end
        PORT_PARK_PIR: begin
          if ((wake_idle || i_ctl.pause_arm) && i_tap_next == TAP_PAUSE_IR) begin
            nxt_q.st = PORT_ACTIVE;
          end
        end
      endcase
    end
    // Follow the backplane while active, else hold 1 in reset and 0 elsewhere.
    if (nxt_q.st == PORT_ACTIVE) begin
      nxt_q.tms = i_tms_b;
    end else begin
      nxt_q.tms = (nxt_q.st == PORT_PARK_TLR);
    end
  end

  // Reset parks the port in Test-Logic-Reset with mode-select high.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q_ff.st <= PORT_PARK_TLR;
      q_ff.tms <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_tms_l = q_ff.tms;
  assign o_unparked = (q_ff.st == PORT_ACTIVE);

endmodule : local_port_ctrl

// [mjas_checker.sv]
// Port assertions for the multidrop address-select bridge.
// Assumes it is bound to the top design module and sees its ports only.
`timescale 1ns/1ps
module mjas_checker
  import bridge_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_tck_b,
  input wire logic o_tdo_b,
  input wire logic o_tdo_b_oe_n,
  input wire logic [port_count-1:0] o_tms_l,
  input wire logic o_local_port_network_in_chain,
  input wire logic o_selected,
  input wire logic o_group_mode
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================================
  // Selection and data-out.
  // Shared data-out stays released in group mode to avoid bus contention.
  group_quiet_a: assert property (o_group_mode |-> o_tdo_b_oe_n)
    else $error("data-out driven in group mode");
  unsel_quiet_a: assert property (!o_selected |-> o_tdo_b_oe_n)
    else $error("data-out driven while unselected");
  group_sel_a: assert property (o_group_mode |-> o_selected)
    else $error("group mode without selection");
  reset_park_a: assert property ($rose(i_rst_n) |-> o_tms_l == 3'b111 && !o_selected)
    else $error("outputs not parked after reset");
  // Depth two: a pin fall that lands on a core edge may already be in the first stage.
  tdo_fall_a: assert property ($changed(o_tdo_b) |-> !$past(i_tck_b, 2))
    else $error("data-out moved outside clock low phase");
  // ==========================================================================
  // Local port network.
  sel_parked_a: assert property ($rose(o_selected) |-> !o_local_port_network_in_chain)
    else $error("network in chain at selection");
  drop_chain_a: assert property ($fell(o_selected) |-> ##[0:2] !o_local_port_network_in_chain)
    else $error("network kept after deselect");
  chain_sel_a: assert property ($rose(o_local_port_network_in_chain) |-> o_selected)
    else $error("unpark while unselected");
endmodule : mjas_checker
bind multidrop_jtag_address_select mjas_checker chk (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_tck_b(i_tck_b), .o_tdo_b(o_tdo_b), .o_tdo_b_oe_n(o_tdo_b_oe_n),
  .o_tms_l(o_tms_l), .o_local_port_network_in_chain(o_local_port_network_in_chain), .o_selected(o_selected),
  .o_group_mode(o_group_mode));

// [multidrop_jtag_address_select.sv]
// Selection, instruction decode and port sequencing of a multidrop test bridge.
// Assumes backplane pins and straps are asynchronous; the test clock is sampled
// by the core clock, which must run well above twice its rate.
`timescale 1ns/1ps
module multidrop_jtag_address_select
  import bridge_pkg::*;
#(
  parameter logic [31:0] IDENT_VALUE = 32'h1234_5001 // Arbitrary identity value.
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_tck_b,
  input wire logic i_tms_b,
  input wire logic i_tdi_b,
  input wire logic [5:0] i_slot,
  input wire logic i_oe_n,
  input wire logic i_local_port_network_tdo,
  output logic o_tdo_b,
  output logic o_tdo_b_oe_n,
  output logic [port_count-1:0] o_tms_l,
  output logic o_local_port_network_tdi,
  output logic o_local_port_network_in_chain,
  output logic o_selected,
  output logic o_group_mode
);

  // ==========================================================================
  // State record of the whole block.
  typedef struct packed {
    pin_sample_t sync1; // First synchroniser stage, read only by sync2.
    pin_sample_t sync2; // Second stage, the only view of the pins.
    logic tck_prev; // Previous sampled test clock for edge finding.
    sel_state_t sel; // Selection state.
    logic [7:0] ir_sh; // Instruction shift stage.
    logic [7:0] ir; // Active instruction.
    logic [31:0] dr; // Shared data register shift path.
    logic [1:0] group; // Group-number register.
    logic [7:0] mode; // Mode register; the top bit is read-only status.
    logic [15:0] sig; // Signature register contents.
    logic [31:0] cnt; // Clock counter contents.
    logic sig_en; // Signature capture enabled.
    logic cnt_en; // Countdown enabled.
    logic tdo; // Backplane data-out value.
    logic tdo_oe_n; // Backplane data-out enable, low drives.
    logic local_port_network_tdi; // Data fed to the local network.
    logic in_chain; // Local network is in the chain.
  } top_reg_t;

  top_reg_t q_ff; // Registered state.
  top_reg_t nxt_q; // Next state.
  pin_sample_t pin; // Synchronised pin view.
  tap_state_t tap_state; // Current backplane TAP state.
  tap_state_t tap_nx; // TAP state after the next rising test clock.
  logic tck_rise; // Enable at a rising test-clock edge.
  logic tck_fall; // Enable at a falling test-clock edge.
  logic selected; // Device is selected by any address.
  port_ctl_t port_ctl; // Commands to the port controllers.
  logic [port_count-1:0] unparked; // Port activity.

  // ==========================================================================
  // Functions.

  // Length of the data register the instruction places in the chain.
  function automatic logic [5:0] dr_len(input logic [7:0] op);
    unique case (op)
      bypass_cmd: dr_len = len_bypass;
      extest_cmd, sample_cmd: dr_len = len_boundary;
      mode_register_select_cmd: dr_len = len_mode;
      group_register_select_cmd: dr_len = len_group;
      signature_register_select_cmd: dr_len = len_signature;
      clock_counter_select_cmd: dr_len = len_counter;
      default: dr_len = len_ident;
    endcase
  endfunction : dr_len

  // Shift one bit into the top of a register of the given length.
  function automatic logic [31:0] dr_shift(input logic [31:0] v, input logic bit_in,
                                           input logic [5:0] len);
    logic [31:0] mask;
    mask = 32'hFFFF_FFFF >> (6'd32 - len);
    dr_shift = ((v >> 1) & mask) | ({31'h0000_0000, bit_in} << (len - 6'd1));
  endfunction : dr_shift

  // ==========================================================================
  // Submodules.

  // Backplane TAP controller.
  bridge_tap_fsm u_tap (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_step(tck_rise),
    .i_tms(pin.tms),
    .o_state(tap_state),
    .o_next(tap_nx)
  );

  // Three local port controllers; the mode register enables each one.
  for (genvar gi = 0; gi < port_count; gi++) begin : g_port
    local_port_ctrl u_port (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_step(tck_rise),
      .i_tap_state(tap_state),
      .i_tap_next(tap_nx),
      .i_tms_b(pin.tms),
      .i_enable(q_ff.mode[gi]),
      .i_ctl(port_ctl),
      .o_tms_l(o_tms_l[gi]),
      .o_unparked(unparked[gi])
    );
  end

  // ==========================================================================
  // Next-state logic.

  // Edges and selection flags derive from registered state only.
  always_comb begin
    pin = q_ff.sync2;
    tck_rise = pin.tck && !q_ff.tck_prev;
    tck_fall = !pin.tck && q_ff.tck_prev;
    selected = (q_ff.sel == SEL_SINGLE) || (q_ff.sel == SEL_GROUP);
  end

  // Main update: selection, instruction and data registers, data-out timing.
  always_comb begin
    nxt_q = q_ff;
    nxt_q.sync1 = {i_tck_b, i_tms_b, i_tdi_b, i_oe_n, i_local_port_network_tdo, i_slot};
    nxt_q.sync2 = q_ff.sync1;
    nxt_q.tck_prev = pin.tck;
    nxt_q.in_chain = |unparked;
    port_ctl = '0;
    port_ctl.force_tlr = (tap_state == TAP_RESET);
    // Arms hold only while the device is selected.
    port_ctl.unpark_arm = selected && (q_ff.ir == unpark_cmd);
    port_ctl.pause_arm = selected && (q_ff.ir == hold_ports_in_pause_cmd);

    if (tap_state == TAP_RESET) begin
      // Test-Logic-Reset returns to waiting and clears the group.
      nxt_q.sel = SEL_WAIT;
      nxt_q.group = group_reset;
      nxt_q.ir = idcode_cmd;
      nxt_q.cnt_en = 1'b0;
      nxt_q.sig_en = 1'b0;
    end
    if (tck_rise) begin
      // The countdown runs at each rising clock until it reaches zero.
      if (q_ff.cnt_en && q_ff.cnt != 32'h0000_0000) begin
        nxt_q.cnt = q_ff.cnt - 32'h0000_0001;
      end
      if (tap_state == TAP_CAP_IR) begin
        nxt_q.ir_sh = {pin.slot, ir_capture_low};
      end
      if (tap_state == TAP_SHIFT_IR) begin
        // Bits leaving the low end are lost unless the device is singly selected.
        nxt_q.ir_sh = {pin.tdi, q_ff.ir_sh[7:1]};
      end
      if (selected && tap_state == TAP_CAP_DR) begin
        unique case (dr_len(q_ff.ir))
          len_bypass: nxt_q.dr = 32'h0000_0000;
          len_boundary: nxt_q.dr = {25'h000_0000, pin.oe_n, pin.slot};
          len_mode: nxt_q.dr = {24'h00_0000, q_ff.cnt_en && q_ff.cnt == 32'h0000_0000,
                                q_ff.mode[6:0]};
          len_group: nxt_q.dr = {30'h0000_0000, q_ff.group};
          len_signature: nxt_q.dr = {16'h0000, q_ff.sig};
          default: begin
            if (q_ff.ir == clock_counter_select_cmd) begin
              nxt_q.dr = q_ff.cnt;
            end else begin
              nxt_q.dr = IDENT_VALUE;
            end
          end
        endcase
      end
      if (selected && tap_state == TAP_SHIFT_DR) begin
        nxt_q.dr = dr_shift(q_ff.dr, pin.tdi, dr_len(q_ff.ir));
      end
      if (selected && tap_nx == TAP_UPD_DR) begin
        // Only writable registers take the shifted value.
        if (q_ff.ir == mode_register_select_cmd) begin
          nxt_q.mode[6:0] = q_ff.dr[6:0];
        end
        if (q_ff.ir == group_register_select_cmd) begin
          nxt_q.group = q_ff.dr[1:0];
        end
        if (q_ff.ir == signature_register_select_cmd) begin
          nxt_q.sig = q_ff.dr[15:0];
        end
        if (q_ff.ir == clock_counter_select_cmd) begin
          nxt_q.cnt = q_ff.dr;
        end
      end
      if (tap_nx == TAP_UPD_IR) begin
        if (q_ff.sel == SEL_WAIT) begin
          // Address decode uses the six low bits; the top two are ignored.
          if (q_ff.ir_sh[5:0] <= addr_direct_max && q_ff.ir_sh[5:0] == pin.slot) begin
            nxt_q.sel = SEL_SINGLE;
          end else if (q_ff.ir_sh[5:0] == addr_broadcast) begin
            nxt_q.sel = SEL_GROUP;
          end else if (q_ff.ir_sh[5:2] == addr_group_prefix
                       && q_ff.ir_sh[1:0] == q_ff.group) begin
            nxt_q.sel = SEL_GROUP;
          end else begin
            nxt_q.sel = SEL_NONE;
          end
          nxt_q.ir = idcode_cmd;
        end else if (q_ff.ir_sh == return_to_wait_cmd) begin
          // Honoured whether selected or not.
          nxt_q.sel = SEL_WAIT;
          nxt_q.ir = idcode_cmd;
          port_ctl.park_tlr = 1'b1;
        end else if (selected) begin
          nxt_q.ir = q_ff.ir_sh;
          unique case (q_ff.ir_sh)
            hold_ports_in_reset_cmd: port_ctl.park_tlr = 1'b1;
            hold_ports_in_idle_cmd: port_ctl.park_rti = 1'b1;
            port_soft_reset_cmd: port_ctl.force_tlr = 1'b1;
            signature_capture_on_cmd: nxt_q.sig_en = 1'b1;
            signature_capture_off_cmd: nxt_q.sig_en = 1'b0;
            clock_countdown_on_cmd: nxt_q.cnt_en = 1'b1;
            clock_countdown_off_cmd: nxt_q.cnt_en = 1'b0;
            default: begin
              // Register selects and other codes only change the chain.
            end
          endcase
        end
      end
    end
    if (tck_fall) begin
      // Data-out changes at the falling edge, as the standard requires.
      nxt_q.tdo_oe_n = 1'b1;
      if (tap_state == TAP_SHIFT_IR) begin
        nxt_q.tdo = q_ff.ir_sh[0];
        nxt_q.tdo_oe_n = (q_ff.sel != SEL_SINGLE);
      end else if (tap_state == TAP_SHIFT_DR) begin
        nxt_q.tdo = q_ff.in_chain ? pin.local_port_network_tdo : q_ff.dr[0];
        nxt_q.tdo_oe_n = (q_ff.sel != SEL_SINGLE);
      end
      nxt_q.local_port_network_tdi = q_ff.dr[0];
    end
  end

  // ==========================================================================
  // Registers. Reset mirrors a test-logic reset with every port parked.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q_ff <= '0;
      q_ff.sel <= SEL_WAIT;
      q_ff.ir <= idcode_cmd;
      q_ff.mode <= mode_reset;
      q_ff.group <= group_reset;
      q_ff.tdo_oe_n <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================================
  // Outputs from flip-flops; the selection flags are decoded from the selection state.
  assign o_tdo_b = q_ff.tdo;
  assign o_tdo_b_oe_n = q_ff.tdo_oe_n;
  assign o_local_port_network_tdi = q_ff.local_port_network_tdi;
  assign o_local_port_network_in_chain = q_ff.in_chain;
  assign o_selected = (q_ff.sel == SEL_SINGLE) || (q_ff.sel == SEL_GROUP);
  assign o_group_mode = (q_ff.sel == SEL_GROUP);

endmodule : multidrop_jtag_address_select

// [test_multidrop_jtag_address_select.sv]
// Self-checking bench for the address-select bridge.
// Assumes bp_ctl as controller and a pull-up on the shared data-out line.
`timescale 1ns/1ps
module test_multidrop_jtag_address_select;
  import bridge_pkg::*;
  localparam logic [31:0] IDV = 32'h5A5A_0001; // Arbitrary identity value.
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_oe_n = 1'b0, i_local_port_network_tdo = 1'b0;
  logic [5:0] i_slot = 6'h00;
  logic [7:0] lf = 8'h14;
  wire tck, tms, tdi;
  logic tdo, oen, inch, sel, grp, lt;
  logic [2:0] tl;
  int error_cnt = 0, samples_checked = 0;
  logic [31:0] exp_q[$], seen;
  event got_ev;
  always #4 i_core_clk = ~i_core_clk;
  bp_ctl ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(oen ? 1'b1 : tdo));
  multidrop_jtag_address_select #(.IDENT_VALUE(IDV)) uut (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_tck_b(tck), .i_tms_b(tms), .i_tdi_b(tdi), .i_slot(i_slot),
    .i_oe_n(i_oe_n), .i_local_port_network_tdo(i_local_port_network_tdo), .o_tdo_b(tdo), .o_tdo_b_oe_n(oen),
    .o_tms_l(tl), .o_local_port_network_tdi(lt), .o_local_port_network_in_chain(inch), .o_selected(sel),
    .o_group_mode(grp));
  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Monitor: the oldest expectation meets each reported result.
  always @(got_ev) begin
    samples_checked++;
    if (seen !== exp_q[0]) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  task automatic note(input logic [31:0] g, input logic [31:0] e);
    exp_q.push_back(e);
    seen = g;
    ->got_ev;
    #1;
  endtask : note
  // Scan from Idle back to Idle; random return data from the network.
  task automatic scan(input logic ir, input int n, input logic [31:0] d,
                      output logic [31:0] q);
    logic b;
    q = '0;
    ctl.step(1'b1, 1'b0, b);
    if (ir) ctl.step(1'b1, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
    for (int k = 0; k < n; k++) begin
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      i_local_port_network_tdo = lf[0];
      ctl.step(k == n - 1, d[k], b);
      q[k] = b;
    end
    ctl.step(1'b1, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
  endtask : scan
  initial begin
    logic [31:0] q;
    logic b;
    logic [5:0] s;
    logic [7:0] ops[9];
    ops = '{8'hC5, 8'h84, 8'hC6, 8'h88, 8'h0C, 8'h8D, 8'h0F, 8'h90, 8'h5A};
    s = 6'(lf % 8'd58);
    i_slot = s;
    i_oe_n = lf[2];
    repeat (4) @(posedge i_core_clk);
    #1 i_rst_n = 1'b1;
    repeat (8) @(posedge i_core_clk);
    ctl.step(1'b0, 1'b0, b);
    scan(1, 8, {26'h0, s ^ 6'h01}, q);
    note(q, 32'hFF);
    scan(1, 8, {24'h0, 2'b00, s}, q);
    note(sel, 1'b0);
    scan(1, 8, 32'hC3, q);
    scan(1, 8, {24'h0, 2'b10, s}, q);
    note({sel, grp}, 2'b10);
    scan(1, 8, 32'hAA, q);
    note(q, {24'h0, s, ir_capture_low});
    scan(0, 32, 0, q);
    note(q, IDV);
    for (int k = 0; k < 2; k++) begin
      scan(1, 8, k ? 32'h81 : 32'h00, q);
      scan(0, 7, 0, q);
      note(q, {25'h0, i_oe_n, s});
    end
    scan(1, 8, 32'hFF, q);
    scan(0, 2, 32'h3, q);
    note(q, 32'h2);
    note(lt, 1'b1);
    scan(1, 8, 32'h8E, q);
    scan(0, 8, 32'h07, q);
    note(q, mode_reset);
    scan(1, 8, 32'h03, q);
    scan(0, 2, 32'h2, q);
    note(q, group_reset);
    // Signature and counter selects: write a value, then read it back.
    for (int k = 0; k < 2; k++) begin
      scan(1, 8, k ? 32'hCE : 32'hC9, q);
      scan(0, k ? 32 : 16, 32'h5A5A, q);
      scan(0, k ? 32 : 16, 0, q);
      note(q, 32'h5A5A);
    end
    foreach (ops[k]) begin
      scan(1, 8, ops[k], q);
      scan(0, 32, 0, q);
      note(q, IDV);
    end
    scan(1, 8, 32'hE7, q);
    note({inch, tl}, 4'b1000);
    scan(1, 8, 32'hC5, q);
    note({inch, tl}, 4'b0111);
    scan(1, 8, 32'hE7, q);
    scan(1, 8, 32'h84, q);
    note({inch, tl}, 4'b0000);
    scan(1, 8, 32'hE7, q);
    note(inch, 1'b1);
    scan(1, 8, 32'hC6, q);
    scan(0, 1, 0, q);
    note({inch, tl}, 4'b0000);
    for (int k = 0; k < 5; k++) ctl.step(k[0], 1'b0, b);
    note(inch, 1'b1);
    for (int k = 0; k < 3; k++) ctl.step(k < 2, 1'b0, b);
    scan(1, 8, 32'hC3, q);
    note({sel, inch, tl}, 5'b00111);
    scan(1, 8, 32'h3E, q);
    note({sel, grp}, 2'b11);
    scan(1, 8, 32'hAA, q);
    note(q, 32'hFF);
    scan(1, 8, 32'hC3, q);
    scan(1, 8, 32'h3D, q);
    note(sel, 1'b0);
    repeat (5) ctl.step(1'b1, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
    scan(1, 8, 32'h3E, q);
    note(sel, 1'b0);
    scan(1, 8, 32'hC3, q);
    scan(1, 8, 32'h3B, q);
    note({sel, grp}, 2'b11);
    finish_test();
  end
  // A hang counts as a mismatch.
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
endmodule : test_multidrop_jtag_address_select
